// *** design/mbsh_defs.svh ***
// Constants for the serial protocol request handler.
`ifndef MBSH_DEFS_SVH
`define MBSH_DEFS_SVH
`define MBSH_FC_RD_COIL 8'h01
`define MBSH_FC_RD_DISC 8'h02
`define MBSH_FC_RD_HOLD 8'h03
`define MBSH_FC_RD_INREG 8'h04
`define MBSH_FC_WR_COIL 8'h05
`define MBSH_FC_WR_HOLD 8'h06
`define MBSH_FC_WR_COILS 8'h0F
`define MBSH_FC_WR_HOLDS 8'h10
`define MBSH_BCAST 8'h00
`define MBSH_ADDR_MIN 8'h01
`define MBSH_ADDR_MAX 8'hF7
`define MBSH_COIL_ON 16'hFF00
`define MBSH_COIL_OFF 16'h0000
`define MBSH_CRC_INIT 16'hFFFF
`define MBSH_CRC_POLY 16'hA001
`define MBSH_NCOIL 16'h0010
`define MBSH_NDISC 16'h0010
`define MBSH_NINREG 16'h0004
`define MBSH_NHOLD 16'h0008
`define MBSH_RXB_LEN 6'h20
`define MBSH_LEN_FIX 6'h08
`define MBSH_LEN_MULTI 6'h09
`define MBSH_LEN_HDR 6'h03
`define MBSH_LEN_WRESP 6'h06
`define MBSH_MDATA0 4'h3
`define MBSH_MLEN 4'h6
`define MBSH_MMIN 4'h5
`define MBSH_OFS_INREG 16'h7531
`define MBSH_OFS_HOLD 16'h9C41
`define MBSH_CLK_NS 40
`define MBSH_TICK_NS 1000000
`endif

// *** design/mbsh_pkg.sv ***
// Types shared by the request handler and its users.
package mbsh_pkg;
    typedef struct packed {
        logic valid;
        logic eof;
        logic [7:0] data;
    } mbsh_rx_t;
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } mbsh_tx_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] fc;
        logic [15:0] num;
        logic [15:0] count;
    } mbsh_mreq_t;
    typedef struct packed {
        logic swap_words;
        logic swap_bytes;
    } mbsh_word_order_t;
    typedef enum logic [1:0] {MBSH_F32, MBSH_I32, MBSH_U16, MBSH_S16} mbsh_fmt_t;
endpackage

// *** design/mbsh_handler.sv ***
// Slave request handler with an independent polling master on one clock.
// Overview of operation
// - Slave serves one node address from 1 to 247 and ignores others.
// - Slave transmits only as the answer to an accepted request.
// - Response holds own address, echoed function, data, then checksum.
// - One request at a time; bytes arriving while busy are dropped.
// - Broadcast address zero reaches every slave.
// - Master and slave roles run at once with separate machines.
// - Code 03 reads holding registers, code 04 reads input registers.
// - Coils are reached by codes 01, 05 and 0F only.
// - Code 02 reads discrete inputs; 01-06, 0F and 10 are served.
// - Code 06 writes one holding register, code 10 several consecutive ones.
// - Storage is coils, discrete inputs, input registers, holding registers.
// - Register requests carry a start number and a count.
// - Master start is 1-based with display offsets 30000 and 40000 removed.
// - Four-byte values take two consecutive registers.
// - Float in two registers is the default value format.
// - Sixteen-bit values take one register and widen to 32 bits, zero-extended for U16 and sign-extended for S16.
// - Multi-byte values are big-endian, most significant byte first.
// - Word order option swaps register halves and bytes within them.
// - Coil reads give one bit each; true sets and false clears.
`include "mbsh_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module mbsh_handler
    import mbsh_pkg::*;
#(
    parameter int MS_CYCLES = (`MBSH_TICK_NS + `MBSH_CLK_NS - 1) / `MBSH_CLK_NS
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] node_addr_in,
    input wire logic [15:0] discrete_in,
    input wire logic [3:0][15:0] inreg_in,
    output logic [15:0] coils_out,
    output logic [7:0][15:0] holding_out,
    input wire mbsh_rx_t slv_rx_in,
    output mbsh_tx_t slv_tx_out,
    output logic slv_tx_valid_out,
    input wire logic slv_tx_ready_in,
    output logic slv_busy_out,
    input wire mbsh_mreq_t mst_req_in,
    input wire logic mst_req_valid_in,
    output logic mst_req_ready_out,
    input wire mbsh_word_order_t word_order_option_in,
    input wire mbsh_fmt_t mst_fmt_in,
    input wire logic [15:0] mst_timeout_in,
    output mbsh_tx_t mst_tx_out,
    output logic mst_tx_valid_out,
    input wire logic mst_tx_ready_in,
    input wire mbsh_rx_t mst_rx_in,
    output logic mst_done_out,
    output logic mst_ok_out,
    output logic mst_timeout_out,
    output logic [31:0] mst_value_out
);
    typedef enum {S_LISTEN, S_EXEC, S_TX} mbsh_sst_t;
    typedef enum {M_IDLE, M_TX, M_WAIT} mbsh_mst_t;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MBSH_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic fits(input logic [15:0] s, input logic [15:0] n,
                                  input logic [15:0] lim);
        return (n != 16'h0000) && ({1'b0, s} + {1'b0, n} <= {1'b0, lim});
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    mbsh_sst_t sst;
    logic [7:0] rxb [0:31];
    logic [5:0] rx_cnt;
    logic rx_ovf;
    logic [15:0] rx_crc;
    logic [15:0] coils;
    logic [7:0][15:0] holding;
    logic [5:0] k;
    logic [15:0] tx_crc;
    logic [7:0] fc;
    logic [15:0] st;
    logic [15:0] cnt;
    logic bcast;
    logic req_ok;
    logic [5:0] n_data;
    logic [15:0] rd_bits;
    logic [15:0] cw;
    logic [7:0] rbyte;
    logic [15:0] rreg;
    logic [5:0] j;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // The buffer stays frozen outside listening, so the fields decode straight from it.
    assign fc = rxb[1];
    assign st = {rxb[2], rxb[3]};
    assign cnt = {rxb[4], rxb[5]};
    assign bcast = (rxb[0] == `MBSH_BCAST);
    assign cw = {rxb[8], rxb[7]};
    assign coils_out = coils;
    assign holding_out = holding;
    assign slv_busy_out = (sst != S_LISTEN);

    always_comb begin
        case (fc)
            `MBSH_FC_RD_COIL: req_ok = fits(st, cnt, `MBSH_NCOIL) && rx_cnt == `MBSH_LEN_FIX;
            `MBSH_FC_RD_DISC: req_ok = fits(st, cnt, `MBSH_NDISC) && rx_cnt == `MBSH_LEN_FIX;
            `MBSH_FC_RD_HOLD: req_ok = fits(st, cnt, `MBSH_NHOLD) && rx_cnt == `MBSH_LEN_FIX;
            `MBSH_FC_RD_INREG: req_ok = fits(st, cnt, `MBSH_NINREG) && rx_cnt == `MBSH_LEN_FIX;
            `MBSH_FC_WR_COIL: req_ok = st < `MBSH_NCOIL && rx_cnt == `MBSH_LEN_FIX &&
                (cnt == `MBSH_COIL_ON || cnt == `MBSH_COIL_OFF);
            `MBSH_FC_WR_HOLD: req_ok = st < `MBSH_NHOLD && rx_cnt == `MBSH_LEN_FIX;
            `MBSH_FC_WR_COILS: req_ok = fits(st, cnt, `MBSH_NCOIL) &&
                rx_cnt == `MBSH_LEN_MULTI + rxb[6][5:0];
            `MBSH_FC_WR_HOLDS: req_ok = fits(st, cnt, `MBSH_NHOLD) &&
                rx_cnt == `MBSH_LEN_MULTI + rxb[6][5:0];
            default: req_ok = 1'b0;
        endcase
    end

    // Unused bits are masked so a partial last byte returns zeros above the count.
    always_comb begin
        rd_bits = ((fc == `MBSH_FC_RD_COIL) ? coils : discrete_in) >> st[3:0];
        rd_bits = rd_bits & ~(16'hFFFF << cnt[4:0]);
        j = k - `MBSH_LEN_HDR;
        rreg = (fc == `MBSH_FC_RD_HOLD) ? holding[3'(st + 16'(j[5:1]))]
                                        : inreg_in[2'(st + 16'(j[5:1]))];
        case (fc)
            `MBSH_FC_RD_COIL, `MBSH_FC_RD_DISC: n_data = `MBSH_LEN_HDR + 6'((cnt + 16'h0007) >> 3);
            `MBSH_FC_RD_HOLD, `MBSH_FC_RD_INREG: n_data = `MBSH_LEN_HDR + 6'(cnt << 1);
            default: n_data = `MBSH_LEN_WRESP;
        endcase
        if (k == 6'h00) begin
            rbyte = node_addr_in;
        end else if (k == 6'h01) begin
            rbyte = fc;
        end else if (n_data == `MBSH_LEN_WRESP) begin
            rbyte = rxb[k[4:0]];
        end else if (k == 6'h02) begin
            rbyte = 8'(n_data - `MBSH_LEN_HDR);
        end else if (fc == `MBSH_FC_RD_HOLD || fc == `MBSH_FC_RD_INREG) begin
            rbyte = j[0] ? rreg[7:0] : rreg[15:8];
        end else begin
            rbyte = j[0] ? rd_bits[15:8] : rd_bits[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Slave request machine.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sst <= S_LISTEN;
            rx_cnt <= 6'h00;
            rx_ovf <= 1'b0;
            rx_crc <= `MBSH_CRC_INIT;
        end else begin
            case (sst)
                S_LISTEN: begin
                    if (slv_rx_in.eof) begin
                        // A checksum over the whole frame including its tail leaves zero.
                        if (rx_crc == 16'h0000 && !rx_ovf && rx_cnt >= `MBSH_LEN_FIX &&
                            (bcast || (rxb[0] == node_addr_in &&
                             node_addr_in >= `MBSH_ADDR_MIN && node_addr_in <= `MBSH_ADDR_MAX))) begin
                            sst <= S_EXEC;
                        end else begin
                            rx_cnt <= 6'h00;
                        end
                        rx_ovf <= 1'b0;
                        rx_crc <= `MBSH_CRC_INIT;
                    end else if (slv_rx_in.valid) begin
                        rx_crc <= crc_step(rx_crc, slv_rx_in.data);
                        if (rx_cnt == `MBSH_RXB_LEN) begin
                            rx_ovf <= 1'b1;
                        end else begin
                            rx_cnt <= rx_cnt + 6'h01;
                        end
                    end
                end
                S_EXEC: begin
                    sst <= (req_ok && !bcast) ? S_TX : S_LISTEN;
                    if (!req_ok || bcast) begin
                        rx_cnt <= 6'h00;
                    end
                end
                S_TX: begin
                    if (k == n_data + 6'h02 && (!slv_tx_valid_out || slv_tx_ready_in)) begin
                        sst <= S_LISTEN;
                        rx_cnt <= 6'h00;
                    end
                end
                default: sst <= S_LISTEN;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sst == S_LISTEN && slv_rx_in.valid && !slv_rx_in.eof && rx_cnt != `MBSH_RXB_LEN) begin
            rxb[rx_cnt[4:0]] <= slv_rx_in.data;
        end
    end

    // Writes land in the execute cycle, before any response byte leaves.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            coils <= 16'h0000;
            holding <= '0;
        end else if (sst == S_EXEC && req_ok) begin
            case (fc)
                `MBSH_FC_WR_COIL: coils[st[3:0]] <= (cnt == `MBSH_COIL_ON);
                `MBSH_FC_WR_HOLD: holding[st[2:0]] <= cnt;
                `MBSH_FC_WR_COILS: begin
                    for (int i = 0; i < 16; i++) begin
                        if (16'(i) >= st && 17'(i) < {1'b0, st} + {1'b0, cnt}) begin
                            coils[i] <= cw[4'(i) - st[3:0]];
                        end
                    end
                end
                `MBSH_FC_WR_HOLDS: begin
                    for (int i = 0; i < 8; i++) begin
                        if (16'(i) >= st && 17'(i) < {1'b0, st} + {1'b0, cnt}) begin
                            holding[i] <= {rxb[5'(7 + 2 * (i - int'(st)))],
                                           rxb[5'(8 + 2 * (i - int'(st)))]};
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // Response bytes are registered; the checksum trails low byte first.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            k <= 6'h00;
            tx_crc <= `MBSH_CRC_INIT;
            slv_tx_valid_out <= 1'b0;
            slv_tx_out <= '0;
        end else if (sst != S_TX) begin
            k <= 6'h00;
            tx_crc <= `MBSH_CRC_INIT;
            slv_tx_valid_out <= 1'b0;
        end else if (!slv_tx_valid_out || slv_tx_ready_in) begin
            if (k == n_data + 6'h02) begin
                slv_tx_valid_out <= 1'b0;
            end else begin
                slv_tx_valid_out <= 1'b1;
                k <= k + 6'h01;
                slv_tx_out.last <= (k == n_data + 6'h01);
                if (k < n_data) begin
                    slv_tx_out.data <= rbyte;
                    tx_crc <= crc_step(tx_crc, rbyte);
                end else begin
                    slv_tx_out.data <= (k == n_data) ? tx_crc[7:0] : tx_crc[15:8];
                end
            end
        end
    end

    p_silent: assert property (slv_tx_valid_out |-> sst == S_TX)
        else $error("slave drives link outside a response");
    property p_no_bcast_resp;
        sst == S_EXEC && bcast |=> sst == S_LISTEN ##1 !slv_tx_valid_out;
    endproperty
    a_no_bcast_resp: assert property (p_no_bcast_resp)
        else $error("broadcast answered");
    property p_bad_crc;
        sst == S_LISTEN && slv_rx_in.eof && rx_crc != 16'h0000 |=> sst == S_LISTEN [*3];
    endproperty
    a_bad_crc: assert property (p_bad_crc)
        else $error("corrupt frame accepted");
    property p_one_at_time;
        sst != S_LISTEN && slv_rx_in.valid |=> $stable(rx_cnt) || sst == S_LISTEN;
    endproperty
    a_one_at_time: assert property (p_one_at_time)
        else $error("byte taken while busy");
    property p_resp_addr;
        $rose(slv_tx_valid_out) |-> slv_tx_out.data == node_addr_in && !bcast;
    endproperty
    a_resp_addr: assert property (p_resp_addr)
        else $error("response does not start with own address");
    property p_wr_hold;
        sst == S_EXEC && req_ok && fc == `MBSH_FC_WR_HOLD |=> holding[st[2:0]] == cnt;
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("single register write lost");
    property p_wr_coil;
        sst == S_EXEC && req_ok && fc == `MBSH_FC_WR_COIL |=>
            coils[st[3:0]] == (cnt == `MBSH_COIL_ON);
    endproperty
    a_wr_coil: assert property (p_wr_coil)
        else $error("single coil write wrong");
    property p_regs_spare_coils;
        sst == S_EXEC && fc inside {`MBSH_FC_RD_HOLD, `MBSH_FC_WR_HOLD, `MBSH_FC_WR_HOLDS}
            |=> $stable(coils);
    endproperty
    a_regs_spare_coils: assert property (p_regs_spare_coils)
        else $error("register code touched coils");
    c_resp: cover property (slv_tx_valid_out && slv_tx_ready_in && slv_tx_out.last);
    c_bcast_write: cover property (sst == S_EXEC && bcast && req_ok);

    ////////////////////////////////////////////////////////////////////////////////
    // Master role; shares no state with the slave machine.
    mbsh_mst_t mst;
    logic [7:0] m_addr;
    logic [7:0] m_fc;
    logic [15:0] m_start;
    logic [15:0] m_qty;
    logic [3:0] mk;
    logic [15:0] m_crc;
    logic [7:0] m_b;
    logic [3:0] mr_cnt;
    logic [15:0] mr_crc;
    logic [7:0] mr_hdr [0:1];
    logic [7:0] mv [0:3];
    logic [31:0] ms_cnt;
    logic [15:0] ms_elapsed;
    logic [31:0] w;

    assign mst_req_ready_out = (mst == M_IDLE);

    always_comb begin
        case (mk)
            4'h0: m_b = m_addr;
            4'h1: m_b = m_fc;
            4'h2: m_b = m_start[15:8];
            4'h3: m_b = m_start[7:0];
            4'h4: m_b = m_qty[15:8];
            default: m_b = m_qty[7:0];
        endcase
        w = {mv[0], mv[1], mv[2], mv[3]};
        if (word_order_option_in.swap_words) begin
            w = {w[15:0], w[31:16]};
        end
        if (word_order_option_in.swap_bytes) begin
            w = {w[23:16], w[31:24], w[7:0], w[15:8]};
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mst <= M_IDLE;
            m_addr <= 8'h00;
            m_fc <= 8'h00;
            m_start <= 16'h0000;
            m_qty <= 16'h0000;
            mk <= 4'h0;
            m_crc <= `MBSH_CRC_INIT;
            mst_tx_valid_out <= 1'b0;
            mst_tx_out <= '0;
            mr_cnt <= 4'h0;
            mr_crc <= `MBSH_CRC_INIT;
            ms_cnt <= 32'h0;
            ms_elapsed <= 16'h0000;
            mst_done_out <= 1'b0;
            mst_ok_out <= 1'b0;
            mst_timeout_out <= 1'b0;
            mst_value_out <= 32'h0;
        end else begin
            mst_done_out <= 1'b0;
            case (mst)
                M_IDLE: begin
                    mk <= 4'h0;
                    m_crc <= `MBSH_CRC_INIT;
                    if (mst_req_valid_in) begin
                        mst <= M_TX;
                        m_addr <= mst_req_in.addr;
                        m_fc <= mst_req_in.fc;
                        if (mst_req_in.fc == `MBSH_FC_RD_INREG && mst_req_in.num > `MBSH_OFS_INREG - 16'h0001) begin
                            m_start <= mst_req_in.num - `MBSH_OFS_INREG;
                        end else if (mst_req_in.fc == `MBSH_FC_RD_HOLD && mst_req_in.num > `MBSH_OFS_HOLD - 16'h0001) begin
                            m_start <= mst_req_in.num - `MBSH_OFS_HOLD;
                        end else begin
                            m_start <= mst_req_in.num - 16'h0001;
                        end
                        // Values of 32 bits need two registers each.
                        m_qty <= ((mst_fmt_in == MBSH_F32 || mst_fmt_in == MBSH_I32) &&
                            mst_req_in.fc inside {`MBSH_FC_RD_HOLD, `MBSH_FC_RD_INREG})
                            ? mst_req_in.count << 1 : mst_req_in.count;
                    end
                end
                M_TX: begin
                    if (!mst_tx_valid_out || mst_tx_ready_in) begin
                        if (mk == `MBSH_MLEN + 4'h2) begin
                            mst_tx_valid_out <= 1'b0;
                            mst <= (m_addr == `MBSH_BCAST) ? M_IDLE : M_WAIT;
                            mst_done_out <= (m_addr == `MBSH_BCAST);
                            mst_ok_out <= 1'b1;
                            mst_timeout_out <= 1'b0;
                            mr_cnt <= 4'h0;
                            mr_crc <= `MBSH_CRC_INIT;
                            ms_cnt <= 32'h0;
                            ms_elapsed <= 16'h0000;
                        end else begin
                            mst_tx_valid_out <= 1'b1;
                            mk <= mk + 4'h1;
                            mst_tx_out.last <= (mk == `MBSH_MLEN + 4'h1);
                            if (mk < `MBSH_MLEN) begin
                                mst_tx_out.data <= m_b;
                                m_crc <= crc_step(m_crc, m_b);
                            end else begin
                                mst_tx_out.data <= (mk == `MBSH_MLEN) ? m_crc[7:0] : m_crc[15:8];
                            end
                        end
                    end
                end
                M_WAIT: begin
                    ms_cnt <= (ms_cnt == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_cnt + 32'h1;
                    if (ms_cnt == 32'(MS_CYCLES - 1)) begin
                        ms_elapsed <= ms_elapsed + 16'h0001;
                    end
                    if (mst_rx_in.eof) begin
                        mst <= M_IDLE;
                        mst_done_out <= 1'b1;
                        mst_ok_out <= mr_crc == 16'h0000 && mr_cnt >= `MBSH_MMIN &&
                            mr_hdr[0] == m_addr && mr_hdr[1] == m_fc;
                        case (mst_fmt_in)
                            MBSH_U16: mst_value_out <= {16'h0000, w[31:16]};
                            MBSH_S16: mst_value_out <= {{16{w[31]}}, w[31:16]};
                            default: mst_value_out <= w;
                        endcase
                    end else if (ms_elapsed == mst_timeout_in) begin
                        mst <= M_IDLE;
                        mst_done_out <= 1'b1;
                        mst_ok_out <= 1'b0;
                        mst_timeout_out <= 1'b1;
                    end else if (mst_rx_in.valid) begin
                        mr_crc <= crc_step(mr_crc, mst_rx_in.data);
                        if (mr_cnt != 4'hF) begin
                            mr_cnt <= mr_cnt + 4'h1;
                        end
                    end
                end
                default: mst <= M_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (mst == M_WAIT && mst_rx_in.valid && !mst_rx_in.eof) begin
            if (mr_cnt < 4'h2) begin
                mr_hdr[mr_cnt[0]] <= mst_rx_in.data;
            end else if (mr_cnt >= `MBSH_MDATA0 && mr_cnt < `MBSH_MDATA0 + 4'h4) begin
                mv[2'(mr_cnt - `MBSH_MDATA0)] <= mst_rx_in.data;
            end
        end
    end

    property p_s16_widen;
        mst_done_out && mst_ok_out && m_addr != `MBSH_BCAST && mst_fmt_in == MBSH_S16 |->
            mst_value_out[31:16] == {16{mst_value_out[15]}};
    endproperty
    a_s16_widen: assert property (p_s16_widen)
        else $error("signed value not widened");
    property p_wait_bound;
        mst == M_WAIT |=> mst == M_WAIT || (mst == M_IDLE && mst_done_out);
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("master left waiting without a done pulse");
    c_mst_ok: cover property (mst_done_out && mst_ok_out && !mst_timeout_out);
    c_mst_timeout: cover property (mst_done_out && mst_timeout_out);
endmodule // mbsh_handler
`default_nettype wire

// *** verification/mbsh_master_model.sv ***
// Polling master model that frames requests for the slave and gathers its replies.
`timescale 1ns/1ps
`default_nettype none
module mbsh_master_model
    import mbsh_pkg::*;
(
    input wire logic clk_in,
    output mbsh_rx_t rx_out,
    input wire mbsh_tx_t tx_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out
);
    logic slow = 1'b0;
    logic corrupt = 1'b0;
    logic [7:0] got[$];
    initial rx_out = '0;
    initial tx_ready_out = 1'b1;
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    // Only this model opens a transfer, and it sends one whole frame at a time.
    task automatic send(input logic [7:0] q[$]);
        logic [15:0] c = crc(q);
        q = {q, c[7:0] ^ {7'h00, corrupt}, c[15:8]};
        got = {};
        foreach (q[i]) begin
            @(posedge clk_in);
            #1 rx_out <= {2'b10, q[i]};
        end
        @(posedge clk_in);
        #1 rx_out <= {2'b01, ~c[15:8]};
        @(posedge clk_in);
        #1 rx_out <= {2'b00, c[15:8]};
    endtask
    // A slow sink stalls every other cycle, so held reply bytes are exercised.
    always @(posedge clk_in) begin
        if (tx_valid_in && tx_ready_out) got.push_back(tx_in.data);
        #1 tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
    end
endmodule // mbsh_master_model
`default_nettype wire

// *** verification/tb_mbsh_handler.sv ***
// Self-checking bench for the slave request handler and its polling master.
`timescale 1ns/1ps
`default_nettype none
module tb_mbsh_handler
    import mbsh_pkg::*;
;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] node = 8'h11;
    logic [15:0] disc = 16'hA5C3;
    logic [3:0][15:0] inreg = {16'h4444, 16'h3333, 16'h2222, 16'hBEEF};
    logic [15:0] coils;
    logic [7:0][15:0] hold;
    logic [7:0] mq[$];
    mbsh_rx_t srx;
    mbsh_tx_t stx, mtx;
    mbsh_mreq_t mreq = '0;
    logic mval = 1'b0;
    logic stv, srdy, mtv, mto, mok, mdone, mrdy, mtrdy, sbusy;
    logic [31:0] mvalue;
    logic [15:0] mtmo = 16'h0001;
    mbsh_word_order_t mwo = '0;
    mbsh_fmt_t mfmt = MBSH_F32;
    mbsh_rx_t mrx;
    int ndone = 0;
    int num_errors = 0;
    int tests_run = 0;
    mbsh_handler #(.MS_CYCLES(4)) u_mbsh_handler (.clk_in(clk_in), .reset_in(reset_in),
        .node_addr_in(node), .discrete_in(disc), .inreg_in(inreg), .coils_out(coils),
        .holding_out(hold), .slv_rx_in(srx), .slv_tx_out(stx), .slv_tx_valid_out(stv),
        .slv_tx_ready_in(srdy), .slv_busy_out(sbusy), .mst_req_in(mreq), .mst_req_valid_in(mval),
        .mst_req_ready_out(mrdy), .word_order_option_in(mwo), .mst_fmt_in(mfmt),
        .mst_timeout_in(mtmo), .mst_tx_out(mtx), .mst_tx_valid_out(mtv),
        .mst_tx_ready_in(mtrdy), .mst_rx_in(mrx), .mst_done_out(mdone), .mst_ok_out(mok),
        .mst_timeout_out(mto), .mst_value_out(mvalue));
    mbsh_master_model u_mbsh_master_model (.clk_in(clk_in), .rx_out(srx), .tx_in(stx),
        .tx_valid_in(stv), .tx_ready_out(srdy));
    mbsh_master_model u_mbsh_master_peer (.clk_in(clk_in), .rx_out(mrx), .tx_in(mtx),
        .tx_valid_in(mtv), .tx_ready_out(mtrdy));
    initial forever #20 clk_in = ~clk_in;
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
    always @(posedge clk_in) if (mtv && mtrdy) mq.push_back(mtx.data);
    always @(posedge clk_in) if (mdone) ndone++;
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // A silent slave leaves the reply empty, so the wait is fixed rather than handshaked.
    task automatic xact(input int n, input logic [71:0] q, input int m, input logic [55:0] r);
        logic [7:0] qq[$];
        logic [7:0] rr[$];
        logic [15:0] c;
        for (int i = n - 1; i >= 0; i--) qq.push_back(q[8*i +: 8]);
        for (int i = m - 1; i >= 0; i--) rr.push_back(r[8*i +: 8]);
        c = u_mbsh_master_model.crc(rr);
        if (m > 0) rr = {rr, c[7:0], c[15:8]};
        u_mbsh_master_model.send(qq);
        repeat (60) @(posedge clk_in);
        check("reply_len", rr.size(), u_mbsh_master_model.got.size());
        foreach (rr[i]) check("reply_byte", rr[i], u_mbsh_master_model.got[i]);
        check("slv_busy", 0, sbusy);
        $display("test %0d done", tests_run);
    endtask
    // One master poll of register 40001; the peer answers only when flags expect success.
    task automatic poll(input mbsh_fmt_t fmt, input logic [1:0] wo, input logic [15:0] tmo,
                        input logic [31:0] d, input logic [31:0] exp, input logic [1:0] flags);
        logic [47:0] rq;
        logic [7:0] r[$];
        rq = {40'h2203000000, (fmt inside {MBSH_U16, MBSH_S16}) ? 8'h01 : 8'h02};
        r = {8'h22, 8'h03, 8'h04, d[31:24], d[23:16], d[15:8], d[7:0]};
        mq = {};
        ndone = 0;
        #1 mfmt = fmt;
        mwo = wo;
        mtmo = tmo;
        mreq = '{8'h22, 8'h03, 16'h9C41, 16'h0001};
        mval = 1'b1;
        @(posedge clk_in);
        #1 mval = 1'b0;
        repeat (12) @(posedge clk_in);
        if (flags[0]) u_mbsh_master_peer.send(r);
        repeat (40) @(posedge clk_in);
        for (int i = 0; i < 6; i++) check("mst_byte", 8'(rq >> 8 * (5 - i)), mq[i]);
        check("mst_len", 8, mq.size());
        check("mst_flags", flags, {mto, mok});
        check("mst_value", exp, mvalue);
        check("mst_done", 1, ndone);
        check("mst_ready", 1, mrdy);
        $display("test %0d done", tests_run);
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        #1 reset_in = 1'b0;
        xact(6, 48'h110600021234, 6, 48'h110600021234);
        check("hold2", 16'h1234, hold[2]);
        u_mbsh_master_model.slow = 1'b1;
        xact(6, 48'h110300010002, 7, 56'h11030400001234);
        xact(6, 48'h110400000001, 5, 40'h110402BEEF);
        xact(6, 48'h11050003FF00, 6, 48'h11050003FF00);
        xact(6, 48'h110100000008, 4, 32'h11010108);
        xact(6, 48'h110200000010, 5, 40'h110202C3A5);
        xact(9, 72'h11100004000102ABCD, 6, 48'h111000040001);
        xact(8, 64'h110F000800020103, 6, 48'h110F00080002);
        check("coils", 16'h0308, coils);
        xact(6, 48'h000600010055, 0, 56'h0);
        check("hold1", 16'h0055, hold[1]);
        xact(6, 48'h120600040001, 0, 56'h0);
        check("hold4", 16'hABCD, hold[4]);
        u_mbsh_master_model.corrupt = 1'b1;
        xact(6, 48'h110600050077, 0, 56'h0);
        u_mbsh_master_model.corrupt = 1'b0;
        check("hold5", 16'h0000, hold[5]);
        poll(MBSH_F32, 2'b00, 16'h0001, 32'h0, 32'h0, 2'b10);
        poll(MBSH_F32, 2'b00, 16'h0010, 32'h41200000, 32'h41200000, 2'b01);
        poll(MBSH_F32, 2'b11, 16'h0010, 32'h12345678, 32'h78563412, 2'b01);
        poll(MBSH_S16, 2'b00, 16'h0010, 32'hF8561234, 32'hFFFFF856, 2'b01);
        summarize();
    end
endmodule // tb_mbsh_handler
`default_nettype wire
